//--- sar_ctrl_pkg.sv
// Constants shared by the converter control port and its SAR sequencer.
// Assumes a single 40 MHz system clock.
package sar_ctrl_pkg;
  // ==========================================================
  // Control byte field positions
  localparam int POWER_HI_BIT = 7;
  localparam int POWER_LO_BIT = 6;
  localparam int ACQ_SEL_BIT = 5;
  localparam int INPUT_CFG_BIT = 4;
  localparam int POLARITY_BIT = 3;
  localparam int CHAN_MSB = 2;
  // Power field codes
  localparam logic [1:0] PWR_FULL_DOWN = 2'h0;
  localparam logic [1:0] PWR_STANDBY = 2'h1;
  localparam logic [1:0] PWR_INT_CLK = 2'h2;
  localparam logic [1:0] PWR_EXT_CLK = 2'h3;
  // Reset values
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic EXT_CLK_RESET = 1'b1;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int CONV_TIME_NS = 3600;
  localparam int CONV_CYCLES = 13;
  localparam int ACQ_CYCLES = 3;
  localparam int INT_DIV =
    (CONV_TIME_NS * (CLK_HZ / 1_000_000)) / (1000 * CONV_CYCLES);
  localparam int RESULT_W = 12;
endpackage : sar_ctrl_pkg

//--- sar_sequencer.sv
// SAR bit-trial sequencer: 13 conversion-clock steps per conversion.
// Assumes comparator input is synchronous to ref_clk.
`timescale 1ns/1ps
module sar_sequencer #(
  parameter int W = sar_ctrl_pkg::RESULT_W
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  input wire logic comp_high,
  // Result
  output logic [W-1:0] trial,
  output logic done
);
  typedef struct packed {
    logic [W-1:0] sar;
    logic [3:0] cnt;
    logic busy;
    logic done;
  } seq_t;
  seq_t r;
  seq_t next_r;

  // ==========================================================
  // One trial per step; last step just flags completion
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    // A start raised by the same write that aborts must win, or the
    // second write of host-ended acquisition would never convert
    if (start) begin
      next_r.busy = 1'b1;
      next_r.cnt = 4'h0;
      next_r.sar = {1'b1, {(W-1){1'b0}}};
    end else if (abort) begin
      next_r.busy = 1'b0;
    end else if (r.busy && step) begin
      if (r.cnt < 4'(W)) begin
        if (!comp_high) begin
          next_r.sar[4'(W-1) - r.cnt] = 1'b0;
        end
        if (r.cnt < 4'(W-1)) begin
          next_r.sar[4'(W-2) - r.cnt] = 1'b1;
        end
      end
      next_r.cnt = r.cnt + 4'h1;
      if (r.cnt == 4'(sar_ctrl_pkg::CONV_CYCLES - 1)) begin
        next_r.busy = 1'b0; // [R18]
        next_r.done = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign trial = r.sar;
  assign done = r.done;
endmodule : sar_sequencer

//--- sar_ctrl_port.sv
// Host-port control logic of a 12-bit SAR converter with 8-bit bus.
// Assumes bus strobes and conv_clk_in are synchronous to ref_clk.
//
// Overview of operation
// R1 - Done output goes low when a conversion result is ready.
// R2 - Done returns high on first read or on a new control write.
// R3 - Power-down codes keep the previously requested clock mode.
// R4 - Top bits: 00 shutdown, 01 standby, 10 internal clk, 11 external.
// R5 - Bit five zero timed acquisition, one host-ended acquisition.
// R6 - Single-ended: three address bits pick positive input, common negative.
// R7 - Differential: upper bits pick pair, lowest bit one makes odd positive.
// R8 - Bit three zero bipolar, one unipolar.
// R9 - External clock mode after reset until changed.
// R10 - Internal clock paces 13 steps to about 3.6 us.
// R11 - Host external clock 100kHz to 7.6MHz, 30 to 70 percent duty.
// R12 - Chip select high ignores clock, strobes and releases the bus.
// R13 - Control byte captured from the eight data lines on write.
// R14 - Result is straight binary unipolar, two's complement bipolar.
// R15 - Host holds chip select and read low for whole read.
// R16 - High byte select zero low eight bits, one upper four bits.
// R17 - High read upper lines are zero unipolar, sign copies bipolar.
// R18 - Every conversion takes thirteen conversion-clock cycles.
// R19 - A write during conversion aborts it and starts acquisition.
// R20 - Timed acquisition ends three clocks after the write.
// R21 - Host-ended acquisition: second write with bit cleared starts conversion. Here only if bits 4:0 repeat the first write.
// R22 - Last result held stable until next conversion completes.
// R23 - Read data driven only while chip select and read are low.
`timescale 1ns/1ps
module sar_ctrl_port (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host bus
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic conv_clk_in,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  output logic conv_done_n,
  // Analog front end
  input wire logic comp_high,
  output logic [2:0] pos_sel,
  output logic neg_common,
  output logic [2:0] neg_sel,
  output logic track,
  output logic [1:0] power_mode,
  output logic unipolar,
  output logic [11:0] dac_code
);
  // ==========================================================
  // Sequencing states; the two acquisition states differ only in
  // what ends them: a step count or a second host write
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ACQ = 4'b0010,
    ST_EXT_ACQ = 4'b0100,
    ST_CONV = 4'b1000
  } state_t;

  // All block state in one record, registered as a whole
  typedef struct packed {
    state_t st;
    logic [7:0] ctrl;
    logic ext_clk;
    logic wr_d;
    logic rd_d;
    logic clk_d;
    logic [1:0] acq_cnt;
    logic [7:0] div;
    logic [11:0] result;
    logic done_n;
    logic [7:0] dout;
    logic oe_n;
    logic [2:0] nsel;
    logic trk;
  } port_t;

  // Current and next state, sequencer handshake and edge strobes
  port_t r;
  port_t next_r;
  logic step;
  logic seq_start;
  logic seq_abort;
  logic seq_done;
  logic [11:0] trial;
  logic wr_rise;
  logic rd_fall;
  logic clk_fall;
  logic int_tick;

  // ==========================================================
  // Edge detectors gated by chip select. The clock history follows the
  // pin even while deselected, so selecting the part with the clock
  // already low is not mistaken for a falling edge.
  assign wr_rise = !cs_n && wr_n && !r.wr_d; // [R12] [R13]
  assign rd_fall = !cs_n && !rd_n && r.rd_d; // [R2]
  assign clk_fall = !cs_n && !conv_clk_in && r.clk_d; // [R12]
  assign int_tick = r.div == 8'(sar_ctrl_pkg::INT_DIV - 1);
  // External clock is ignored in internal mode; divider paces it instead
  assign step = r.ext_clk ? clk_fall : int_tick; // [R10]
  assign seq_abort = wr_rise; // [R19]

  // Bit-trial engine; its done pulse lasts one cycle, so the state
  // machine must be in conversion to catch it
  sar_sequencer #(.W(sar_ctrl_pkg::RESULT_W)) u_seq (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .start(seq_start),
    .abort(seq_abort),
    .step(step),
    .comp_high(comp_high),
    .trial(trial),
    .done(seq_done)
  );

  // ==========================================================
  // Control sequencing, result hold and bus drive
  always_comb begin
    next_r = r;
    seq_start = 1'b0;
    next_r.wr_d = cs_n ? 1'b1 : wr_n;
    next_r.rd_d = cs_n ? 1'b1 : rd_n;
    next_r.clk_d = conv_clk_in;
    next_r.div = int_tick ? 8'h00 : r.div + 8'h01;
    if (wr_rise) begin
      next_r.ctrl = data_in; // [R13]
      next_r.done_n = 1'b1; // [R2]
      // Power-down codes leave the clock mode alone
      if (data_in[sar_ctrl_pkg::POWER_HI_BIT]) begin
        next_r.ext_clk = data_in[sar_ctrl_pkg::POWER_LO_BIT]; // [R3] [R4]
      end
      next_r.acq_cnt = 2'h0;
      // Second write must repeat input, polarity and channel bits;
      // only the power bits and the cleared acquisition bit may change between the two writes
      if (r.st == ST_EXT_ACQ && !data_in[sar_ctrl_pkg::ACQ_SEL_BIT] &&
          data_in[sar_ctrl_pkg::INPUT_CFG_BIT:0] ==
          r.ctrl[sar_ctrl_pkg::INPUT_CFG_BIT:0]) begin
        next_r.st = ST_CONV; // [R21]
        seq_start = 1'b1;
      end else if (data_in[sar_ctrl_pkg::ACQ_SEL_BIT]) begin
        next_r.st = ST_EXT_ACQ; // [R5]
      end else begin
        next_r.st = ST_ACQ; // [R5] [R19]
      end
    end else begin
      case (r.st)
        ST_IDLE: begin
        end
        ST_ACQ: begin
          if (step) begin
            next_r.acq_cnt = r.acq_cnt + 2'h1;
            if (r.acq_cnt == 2'(sar_ctrl_pkg::ACQ_CYCLES - 1)) begin
              next_r.st = ST_CONV; // [R20]
              seq_start = 1'b1;
            end
          end
        end
        ST_EXT_ACQ: begin
        end
        ST_CONV: begin
          if (seq_done) begin
            next_r.st = ST_IDLE;
            next_r.result = trial; // [R22] [R14]
            next_r.done_n = 1'b0; // [R1]
          end
        end
        default: next_r.st = ST_IDLE;
      endcase
      // A read meeting a completing conversion loses: the new result
      // must still be flagged, so the set wins
      if (rd_fall && !(r.st == ST_CONV && seq_done)) begin
        next_r.done_n = 1'b1; // [R2]
      end
    end
    // Read mux: high byte carries sign or zero fill
    next_r.oe_n = !(!cs_n && !rd_n); // [R23] [R12]
    if (high_byte_select) begin
      next_r.dout = {{4{r.result[11] &
                        !r.ctrl[sar_ctrl_pkg::POLARITY_BIT]}},
                     r.result[11:8]}; // [R16] [R17]
    end else begin
      next_r.dout = r.result[7:0]; // [R16]
    end
    // Mux select and track follow the next state, so these outputs come
    // from flops yet change in step with the control register
    next_r.nsel = {next_r.ctrl[2:1], ~next_r.ctrl[0]}; // [R7]
    next_r.trk = (next_r.st == ST_ACQ) || (next_r.st == ST_EXT_ACQ);
  end

  // ==========================================================
  // State register; reset puts the part in external clock mode with
  // the bus released and the done flag high
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
      r.st <= ST_IDLE;
      r.ctrl <= sar_ctrl_pkg::CTRL_RESET;
      r.ext_clk <= sar_ctrl_pkg::EXT_CLK_RESET; // [R9]
      r.wr_d <= 1'b1;
      r.rd_d <= 1'b1;
      r.clk_d <= 1'b0;
      r.done_n <= 1'b1;
      r.oe_n <= 1'b1;
      r.nsel <= {sar_ctrl_pkg::CTRL_RESET[2:1],
                 ~sar_ctrl_pkg::CTRL_RESET[0]};
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // Mux decode; result holds the raw SAR code for both polarities
  assign pos_sel = r.ctrl[sar_ctrl_pkg::INPUT_CFG_BIT] ? r.ctrl[2:0] :
                   r.ctrl[2:0]; // [R6] [R7]
  assign neg_sel = r.nsel; // [R7]
  assign neg_common = r.ctrl[sar_ctrl_pkg::INPUT_CFG_BIT]; // [R6]
  assign track = r.trk;
  assign power_mode = r.ctrl[7:6]; // [R4]
  assign unipolar = r.ctrl[sar_ctrl_pkg::POLARITY_BIT]; // [R8]
  assign dac_code = trial;
  assign data_out = r.dout;
  assign data_oe_n = r.oe_n;
  assign conv_done_n = r.done_n;
endmodule : sar_ctrl_port

//--- sar_ctrl_port_assertions.sv
// Pin-level checks of the converter control port.
// Bound onto sar_ctrl_port; sees its ports only.
`timescale 1ns/1ps
module sar_ctrl_port_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Host bus
  input wire logic cs_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic high_byte_select,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  input wire logic conv_done_n,
  // Mux and mode
  input wire logic [2:0] pos_sel,
  input wire logic [2:0] neg_sel,
  input wire logic neg_common,
  input wire logic [1:0] power_mode,
  input wire logic unipolar
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // =====
  // Write taken as wr_n rises; a read lasts while both strobes are low
  sequence s_wr; !cs_n && wr_n && $past(!wr_n); endsequence
  sequence s_rd; !cs_n && !rd_n; endsequence
  property p_rel; !data_oe_n |-> $past(!cs_n && !rd_n); endproperty
  a_rel: assert property (p_rel) else $error("bus driven");
  property p_drv; s_rd |=> !data_oe_n; endproperty
  a_drv: assert property (p_drv) else $error("bus not driven");
  property p_uni; s_rd and (high_byte_select && unipolar)
    |=> data_out[7:4] == 4'h0; endproperty
  a_uni: assert property (p_uni) else $error("high nibble");
  property p_bip; s_rd and (high_byte_select && !unipolar)
    |=> data_out[7:4] == {4{data_out[3]}}; endproperty
  a_bip: assert property (p_bip) else $error("sign copies");
  property p_ctrl; s_wr |=> power_mode == $past(data_in[7:6])
    && unipolar == $past(data_in[3]); endproperty
  a_ctrl: assert property (p_ctrl) else $error("mode");
  property p_mux; s_wr |=> neg_common == $past(data_in[4])
    && pos_sel == $past(data_in[2:0])
    && (neg_common || neg_sel == (pos_sel ^ 3'h1)); endproperty
  a_mux: assert property (p_mux) else $error("mux select");
  property p_wclr; s_wr |=> conv_done_n; endproperty
  a_wclr: assert property (p_wclr) else $error("done on write");
  property p_rclr; s_rd and ($past(rd_n) && !conv_done_n)
    |=> conv_done_n;
  endproperty
  a_rclr: assert property (p_rclr) else $error("done on read");
endmodule : sar_ctrl_port_checker
bind sar_ctrl_port sar_ctrl_port_checker chk (.ref_clk, .nrst, .cs_n,
  .wr_n, .rd_n, .high_byte_select, .data_in, .data_out, .data_oe_n,
  .conv_done_n, .pos_sel, .neg_sel, .neg_common, .power_mode, .unipolar);

//--- host_bus_model.sv
// Host processor model: control writes, reads and conversion clock.
// Changes its pins only at falling edges of ref_clk.
`timescale 1ns/1ps
module host_bus_model (
  // Clock
  input wire logic ref_clk,
  // Host bus, idle released
  output logic cs_n = 1'h1,
  output logic wr_n = 1'h1,
  output logic rd_n = 1'h1,
  output logic high_byte_select = 1'h0,
  output logic conv_clk_in = 1'h0,
  output logic [7:0] data_in = 8'h00,
  input wire logic [7:0] data_out
);
  // One bus cycle; idle data is inverted so stale bytes never linger
  task automatic cyc(input logic w, input logic hb, input logic [7:0] b,
                     output logic [7:0] v);
    @(negedge ref_clk);
    cs_n = 1'h0;
    wr_n = ~w;
    rd_n = w;
    high_byte_select = hb;
    data_in = b;
    @(negedge ref_clk);
    wr_n = 1'h1;
    @(negedge ref_clk);
    v = data_out;
    cs_n = 1'h1;
    rd_n = 1'h1;
    data_in = ~b;
  endtask : cyc
  // Clock steps at about 5.71 MHz, high 3 of 7 cycles (about 43 percent duty); sel low keeps cs_n high
  task automatic step(input int n, input logic sel);
    repeat (n) begin
      @(negedge ref_clk);
      cs_n = ~sel;
      conv_clk_in = 1'h1;
      repeat (3) @(negedge ref_clk);
      conv_clk_in = 1'h0;
      repeat (3) @(negedge ref_clk);
      cs_n = 1'h1;
    end
  endtask : step
endmodule : host_bus_model

//--- sar_ctrl_port_tb_top.sv
// Self-checking bench for the converter control port.
// Host model drives the bus; comparator follows a target code.
`timescale 1ns/1ps
module sar_ctrl_port_tb_top;
  logic ref_clk, nrst, comp_high, cs_n, wr_n, rd_n, high_byte_select;
  logic conv_clk_in, data_oe_n, conv_done_n, neg_common, track, unipolar;
  logic [7:0] data_in, data_out, v;
  logic [2:0] pos_sel, neg_sel;
  logic [1:0] power_mode;
  logic [11:0] dac_code, target;
  logic [31:0] seed;
  int fails, n_checks;
  // =====
  // Clock and a comparator that keeps trials up to the target
  initial begin
    ref_clk = 1'h0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(negedge ref_clk) comp_high <= (dac_code <= target);
  sar_ctrl_port dut (.ref_clk, .nrst, .cs_n, .wr_n, .rd_n,
    .high_byte_select, .conv_clk_in, .data_in, .data_out, .data_oe_n,
    .conv_done_n, .comp_high, .pos_sel, .neg_common, .neg_sel, .track,
    .power_mode, .unipolar, .dac_code);
  host_bus_model m (.ref_clk, .cs_n, .wr_n, .rd_n, .high_byte_select,
    .conv_clk_in, .data_in, .data_out);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic [11:0] hi_exp(input logic u, input logic [11:0] t);
    return {4'h0, u ? 4'h0 : {4{t[11]}}, t[11:8]};
  endfunction : hi_exp
  task automatic chk(input string nm, input logic [11:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Write, give k steps, then read both bytes
  task automatic conv(input logic [7:0] b, input logic [11:0] t, input int k);
    target = t;
    m.cyc(1'h1, 1'h0, b, v);
    m.step(k - 1, 1'h1);
    chk("early", 12'h1, 12'(conv_done_n));
    m.step(1, 1'h1);
    chk("done", 12'h0, 12'(conv_done_n));
    m.cyc(1'h0, 1'h0, 8'h00, v);
    chk("low", 12'(t[7:0]), 12'(v));
    chk("clear", 12'h1, 12'(conv_done_n));
    m.cyc(1'h0, 1'h1, 8'h00, v);
    chk("high", hi_exp(b[3], t), 12'(v));
  endtask : conv
  // Internal clock: no steps given, time bounded around 16 divider spans
  task automatic timed(input logic [7:0] b, input logic [11:0] t);
    int n;
    n = 0;
    target = t;
    m.cyc(1'h1, 1'h0, b, v);
    while (conv_done_n !== 1'h0 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk("int_time", 12'h1, 12'(n > 15 * sar_ctrl_pkg::INT_DIV
      && n < 17 * sar_ctrl_pkg::INT_DIV + 4));
    m.cyc(1'h0, 1'h0, 8'h00, v);
    chk("int_low", 12'(t[7:0]), 12'(v));
  endtask : timed
  task automatic report_and_stop();
    if (fails == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  initial begin
    nrst = 1'h0;
    comp_high = 1'h0;
    target = 12'h000;
    seed = 32'h0000_4A1D;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'h1;
    chk("rst", 12'h3, {8'h0, power_mode, data_oe_n, conv_done_n});
    conv(8'h48, 12'hA5C, 16);
    conv(8'hC0, 12'h800, 16);
    conv(8'hD8, 12'hFFF, 16);
    repeat (12) begin
      seed = xs();
      conv({3'h6, seed[4:0]}, seed[27:16], 16);
    end
    m.cyc(1'h1, 1'h0, 8'hC8, v);
    m.step(8, 1'h1);
    m.step(20, 1'h0);
    chk("cs_high", 12'h1, 12'(conv_done_n));
    conv(8'hC9, 12'h3C3, 16);
    m.cyc(1'h1, 1'h0, 8'hE8, v);
    m.step(20, 1'h1);
    chk("ext_acq", 12'h1, 12'(conv_done_n));
    conv(8'hC8, 12'h5A5, 13);
    timed(8'h98, 12'h1F0);
    timed(8'h58, 12'h0E1);
    timed(8'h18, 12'h71E);
    report_and_stop();
  end
  // Watchdog: the sequence needs about 3000 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    report_and_stop();
  end
endmodule : sar_ctrl_port_tb_top
